// file: rtl/seb_target.sv
////////////////////////////////////////////////////////////////////////////////
module seb_target #(
   parameter int unsigned WRITE_CYCLES = seb_pkg::WR_CYC
) (
   input wire logic CLK,                             // Core clock
   input wire logic NRST,                            // Async reset, active low
   input wire logic SCL,                             // Serial clock pin
   input wire logic SDA_LVL,                         // Serial data pin level
   output logic SDA_DRV,                             // Serial data drive value
   output logic SDA_OE,                              // Serial data pull enable
   input wire logic CHIP_SELECT_HIGH,                // Hardwired select, upper
   input wire logic CHIP_SELECT_LOW,                 // Hardwired select, lower
   input wire logic WRITE_PROTECT,                   // Array write protect pin
   output logic WR_VALID,                            // Write word available
   input wire logic WR_READY,                        // Write word taken
   output logic [seb_pkg::ADDR_W-1:0] WR_ADDR,       // Write word address
   output logic [seb_pkg::BYTE_W-1:0] WR_DATA,       // Write word data
   output logic [seb_pkg::ADDR_W-1:0] RD_ADDR,       // Read address to array
   input wire logic [seb_pkg::BYTE_W-1:0] RD_DATA,   // Read data from array
   output logic BUSY,                                // Internal write cycle
   output logic STANDBY                              // Low-power standby
);
   localparam int unsigned CW = $clog2(WRITE_CYCLES + 1);
   localparam int unsigned AW = seb_pkg::ADDR_W;
   localparam int unsigned BW = seb_pkg::BYTE_W;
   localparam int unsigned PW = seb_pkg::PAGE_AW;

   if (WRITE_CYCLES < 1) begin : g_bad_cycles
      $error("seb_target needs a write cycle of at least one clock");
   end
   if ((1 << AW) != seb_pkg::PAGE_COUNT * seb_pkg::PAGE_BYTES) begin : g_bad_map
      $error("seb_target address width does not cover the array");
   end

   typedef struct packed {
      seb_pkg::seb_state_e st;
      logic scl_q;
      logic sda_q;
      logic [3:0] bit_cnt;
      logic [1:0] byte_ix;
      logic [BW-1:0] shreg;
      logic rd_mode;
      logic ack;
      logic m_ack;
      logic [AW-1:0] waddr;
      logic oe;
      logic push;
      logic [seb_pkg::WR_W-1:0] push_data;
      logic pending;
      logic busy;
      logic [CW-1:0] busy_cnt;
   } seb_target_s;

   seb_target_s r_ff;
   seb_target_s nxt_r;

   logic scl_s;
   logic sda_s;
   logic wp_s;
   logic [1:0] cs_s;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   seb_stream_if #(.W(seb_pkg::WR_W)) fill_if ();
   seb_stream_if #(.W(seb_pkg::WR_W)) drain_if ();

   ////////////////////////////////////////////////////////////////////////////////
   // Device word decode, used by the acknowledge; its check recomputes the compare
   function automatic logic dev_match(input logic [BW-1:0] w, input logic [1:0] cs);
      logic type_ok;
      logic cs_ok;
      type_ok = (w[BW-1:seb_pkg::DEV_TYPE_LSB] == seb_pkg::DEV_TYPE);
      cs_ok = ({w[seb_pkg::DEV_CS_HI_BIT], w[seb_pkg::DEV_CS_LO_BIT]} == cs);
      return type_ok & cs_ok;
   endfunction

   // Page-local increment for writes: upper bits keep the page
   function automatic logic [AW-1:0] page_inc(input logic [AW-1:0] a);
      return {a[AW-1:PW], a[PW-1:0] + 1'h1};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Every pin level passes two flops; a floating select settles low at the pad
   seb_sync #(.N(5)) u_sync (
      .clk(CLK),
      .nrst(NRST),
      .d({SCL, SDA_LVL, WRITE_PROTECT, CHIP_SELECT_HIGH, CHIP_SELECT_LOW}),
      .q({scl_s, sda_s, wp_s, cs_s})
   );

   // Edges seen on the synchronised pair
   assign scl_rise = scl_s & ~r_ff.scl_q;
   assign scl_fall = ~scl_s & r_ff.scl_q;
   assign start_ev = scl_s & r_ff.scl_q & r_ff.sda_q & ~sda_s;
   assign stop_ev = scl_s & r_ff.scl_q & ~r_ff.sda_q & sda_s;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus protocol engine
   always_comb begin
      nxt_r = r_ff;
      nxt_r.scl_q = scl_s;
      nxt_r.sda_q = sda_s;
      nxt_r.push = 1'h0;
      // Internal write countdown
      if (r_ff.busy) begin
         nxt_r.busy_cnt = r_ff.busy_cnt - 1'h1;
         if (r_ff.busy_cnt == CW'(1)) begin
            nxt_r.busy = 1'h0;
         end
      end
      if (r_ff.busy) begin
         // Deaf to the bus until the cycle ends
         nxt_r.st = seb_pkg::ST_STANDBY;
         nxt_r.oe = 1'h0;
      end else if (stop_ev) begin
         nxt_r.st = seb_pkg::ST_STANDBY;
         nxt_r.oe = 1'h0;
         if (r_ff.pending) begin
            nxt_r.busy = 1'h1;
            nxt_r.busy_cnt = CW'(WRITE_CYCLES);
            nxt_r.pending = 1'h0;
         end
      end else if (start_ev) begin
         // A start outside the internal write cycle drops what was under way
         nxt_r.st = seb_pkg::ST_RECV;
         nxt_r.bit_cnt = '0;
         nxt_r.byte_ix = seb_pkg::IX_DEV;
         nxt_r.oe = 1'h0;
      end else begin
         unique case (r_ff.st)
            seb_pkg::ST_STANDBY: begin
               nxt_r.oe = 1'h0;
            end
            seb_pkg::ST_RECV: begin
               if (scl_rise && r_ff.bit_cnt != seb_pkg::BITS_PER_WORD) begin
                  nxt_r.shreg = {r_ff.shreg[BW-2:0], sda_s};
                  nxt_r.bit_cnt = r_ff.bit_cnt + 1'h1;
               end else if (scl_fall && r_ff.bit_cnt == seb_pkg::BITS_PER_WORD) begin
                  nxt_r.st = seb_pkg::ST_ACK;
                  nxt_r.bit_cnt = '0;
                  unique case (r_ff.byte_ix)
                     seb_pkg::IX_DEV: begin
                        nxt_r.ack = dev_match(r_ff.shreg, cs_s);
                        nxt_r.rd_mode = r_ff.shreg[seb_pkg::DEV_RW_BIT];
                        if (!r_ff.shreg[seb_pkg::DEV_RW_BIT]) begin
                           nxt_r.waddr[AW-1] = r_ff.shreg[seb_pkg::DEV_TOP_BIT];
                        end
                     end
                     seb_pkg::IX_AHI: begin
                        nxt_r.ack = 1'h1;
                        nxt_r.waddr[AW-2:BW] = r_ff.shreg;
                     end
                     seb_pkg::IX_ALO: begin
                        nxt_r.ack = 1'h1;
                        nxt_r.waddr[BW-1:0] = r_ff.shreg;
                     end
                     seb_pkg::IX_DATA: begin
                        // Protected or full buffer: word refused, not acknowledged
                        nxt_r.ack = ~wp_s & fill_if.ready;
                        if (~wp_s & fill_if.ready) begin
                           nxt_r.push = 1'h1;
                           nxt_r.push_data = {r_ff.waddr, r_ff.shreg};
                           nxt_r.pending = 1'h1;
                           nxt_r.waddr = page_inc(r_ff.waddr);
                        end
                     end
                  endcase
                  nxt_r.oe = nxt_r.ack;
               end
            end
            seb_pkg::ST_ACK: begin
               if (scl_fall) begin
                  nxt_r.oe = 1'h0;
                  nxt_r.bit_cnt = '0;
                  if (!r_ff.ack) begin
                     nxt_r.st = seb_pkg::ST_STANDBY;
                  end else if (r_ff.byte_ix == seb_pkg::IX_DEV && r_ff.rd_mode) begin
                     nxt_r.st = seb_pkg::ST_SEND;
                     nxt_r.shreg = RD_DATA;
                     nxt_r.oe = ~RD_DATA[BW-1];
                  end else begin
                     nxt_r.st = seb_pkg::ST_RECV;
                     if (r_ff.byte_ix != seb_pkg::IX_DATA) begin
                        nxt_r.byte_ix = r_ff.byte_ix + 1'h1;
                     end
                  end
               end
            end
            seb_pkg::ST_SEND: begin
               if (scl_fall) begin
                  if (r_ff.bit_cnt == seb_pkg::LAST_OUT_BIT) begin
                     nxt_r.st = seb_pkg::ST_MACK;
                     nxt_r.oe = 1'h0;
                  end else begin
                     nxt_r.bit_cnt = r_ff.bit_cnt + 1'h1;
                     nxt_r.shreg = {r_ff.shreg[BW-2:0], 1'h0};
                     nxt_r.oe = ~r_ff.shreg[BW-2];
                  end
               end
            end
            seb_pkg::ST_MACK: begin
               // Counter moves on at the ack bit, giving the array time to answer
               if (scl_rise) begin
                  nxt_r.m_ack = ~sda_s;
                  nxt_r.waddr = r_ff.waddr + 1'h1;
               end else if (scl_fall) begin
                  nxt_r.bit_cnt = '0;
                  if (r_ff.m_ack) begin
                     nxt_r.st = seb_pkg::ST_SEND;
                     nxt_r.shreg = RD_DATA;
                     nxt_r.oe = ~RD_DATA[BW-1];
                  end else begin
                     nxt_r.st = seb_pkg::ST_STANDBY;
                  end
               end
            end
            // Unused state codes fall back to idle
            default: begin
               nxt_r.st = seb_pkg::ST_STANDBY;
               nxt_r.oe = 1'h0;
            end
         endcase
      end
   end

   // State register; power-up lands in standby
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         r_ff <= '{st: seb_pkg::ST_STANDBY, default: '0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write words queue here so a slow array port loses nothing
   assign fill_if.valid = r_ff.push;
   assign fill_if.data = r_ff.push_data;
   assign drain_if.ready = WR_READY;

   seb_buf #(.W(seb_pkg::WR_W), .DEPTH(seb_pkg::BUF_DEPTH)) u_buf (
      .clk(CLK),
      .nrst(NRST),
      .in_s(fill_if),
      .out_s(drain_if)
   );

   // Output pins; the line is only ever pulled low
   assign SDA_DRV = 1'h0;
   assign SDA_OE = r_ff.oe;
   assign WR_VALID = drain_if.valid;
   assign {WR_ADDR, WR_DATA} = drain_if.data;
   assign RD_ADDR = r_ff.waddr;
   assign BUSY = r_ff.busy;
   assign STANDBY = (r_ff.st == seb_pkg::ST_STANDBY) & ~r_ff.busy;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks on the protocol engine
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   a_pull_states: assert property (
      SDA_OE |-> (r_ff.st == seb_pkg::ST_ACK || r_ff.st == seb_pkg::ST_SEND))
      else $error("data line pulled outside ack or send");

   a_drive_on_fall: assert property (
      $rose(SDA_OE) |-> $past(scl_fall))
      else $error("data line pulled other than at clock fall");

   a_start_restart: assert property (
      (start_ev && !r_ff.busy) |=> (r_ff.st == seb_pkg::ST_RECV && r_ff.bit_cnt == '0
         && r_ff.byte_ix == seb_pkg::IX_DEV))
      else $error("start did not restart address reception");

   a_stop_standby: assert property (
      stop_ev |=> STANDBY || BUSY)
      else $error("stop did not reach standby");

   a_ninth_ack: assert property (
      (scl_fall && r_ff.st == seb_pkg::ST_RECV && r_ff.bit_cnt == seb_pkg::BITS_PER_WORD
         && r_ff.byte_ix != seb_pkg::IX_DEV && r_ff.byte_ix != seb_pkg::IX_DATA
         && !stop_ev && !start_ev && !r_ff.busy) |=> SDA_OE)
      else $error("address byte not acknowledged");

   a_dev_match: assert property (
      ($rose(r_ff.st == seb_pkg::ST_ACK) && r_ff.byte_ix == seb_pkg::IX_DEV)
         |-> (r_ff.ack == ($past(r_ff.shreg[BW-1:seb_pkg::DEV_TYPE_LSB]) == seb_pkg::DEV_TYPE
         && $past({r_ff.shreg[seb_pkg::DEV_CS_HI_BIT], r_ff.shreg[seb_pkg::DEV_CS_LO_BIT]})
         == $past(cs_s))))
      else $error("device word acknowledge does not follow the compare");

   a_wp_refuse: assert property (
      r_ff.push |-> $past(!wp_s))
      else $error("word queued while write protect was high");

   a_busy_deaf: assert property (
      BUSY |-> (!SDA_OE && !r_ff.push) ##1 (!SDA_OE [*3]))
      else $error("bus answered during internal write");

   a_read_send: assert property (
      (r_ff.st == seb_pkg::ST_ACK && scl_fall && r_ff.ack && r_ff.rd_mode
         && r_ff.byte_ix == seb_pkg::IX_DEV && !start_ev && !stop_ev && !r_ff.busy)
         |=> r_ff.st == seb_pkg::ST_SEND)
      else $error("read direction did not start sending");
endmodule // seb_target

// file: common/seb_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types for the two-wire memory bus target
package seb_pkg;
   // Clock and internal write timing
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned INTERNAL_WRITE_TIME_US = 5000;
   localparam int unsigned WR_CYC = (CLK_HZ / 1_000_000) * INTERNAL_WRITE_TIME_US;

   // Array organisation
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned ADDR_W = 17;
   localparam int unsigned PAGE_COUNT = 512;
   localparam int unsigned PAGE_BYTES = 256;
   localparam int unsigned PAGE_AW = 8;
   localparam int unsigned WR_W = ADDR_W + BYTE_W;
   localparam int unsigned BUF_DEPTH = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Device address word layout
   localparam logic [3:0] DEV_TYPE = 4'hA;
   localparam int unsigned DEV_RW_BIT = 0;
   localparam int unsigned DEV_TOP_BIT = 1;
   localparam int unsigned DEV_CS_LO_BIT = 2;
   localparam int unsigned DEV_CS_HI_BIT = 3;
   localparam int unsigned DEV_TYPE_LSB = 4;

   // Bit and byte counting
   localparam logic [3:0] BITS_PER_WORD = 4'h8;
   localparam logic [3:0] LAST_OUT_BIT = 4'h7;
   localparam logic [1:0] IX_DEV = 2'h0;
   localparam logic [1:0] IX_AHI = 2'h1;
   localparam logic [1:0] IX_ALO = 2'h2;
   localparam logic [1:0] IX_DATA = 2'h3;

   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_RECV,
      ST_ACK,
      ST_SEND,
      ST_MACK
   } seb_state_e;
endpackage

// file: common/seb_stream_if.sv
////////////////////////////////////////////////////////////////////////////////
// Valid/ready word stream between the target core and its buffer
interface seb_stream_if #(parameter int unsigned W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// file: rtl/seb_sync.sv
////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser for pin levels
module seb_sync #(
   parameter int unsigned N = 1
) (
   input wire logic clk,           // Core clock
   input wire logic nrst,          // Async reset, active low
   input wire logic [N-1:0] d,     // Asynchronous levels
   output logic [N-1:0] q          // Synchronised levels
);
   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
   } seb_sync_s;

   seb_sync_s r_ff;
   seb_sync_s nxt_r;

   if (N < 1) begin : g_bad_n
      $error("seb_sync needs at least one bit");
   end

   // First stage feeds only the second
   always_comb begin
      nxt_r = r_ff;
      nxt_r.s1 = d;
      nxt_r.s2 = r_ff.s1;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign q = r_ff.s2;
endmodule // seb_sync

// file: rtl/seb_buf.sv
////////////////////////////////////////////////////////////////////////////////
// Small flop FIFO holding accepted write words
module seb_buf #(
   parameter int unsigned W = 8,
   parameter int unsigned DEPTH = 2
) (
   input wire logic clk,           // Core clock
   input wire logic nrst,          // Async reset, active low
   seb_stream_if.snk in_s,         // Fill side
   seb_stream_if.src out_s         // Drain side
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } seb_buf_s;

   seb_buf_s r_ff;
   seb_buf_s nxt_r;
   logic push;
   logic pop;

   // Pointers wrap naturally, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("seb_buf depth must be a power of two, at least 2");
   end

   // Honest full and empty from the occupancy count
   assign in_s.ready = (r_ff.cnt != FULL);
   assign out_s.valid = (r_ff.cnt != '0);
   assign out_s.data = r_ff.mem[r_ff.rp];
   assign push = in_s.valid & in_s.ready;
   assign pop = out_s.valid & out_s.ready;

   always_comb begin
      nxt_r = r_ff;
      if (push) begin
         nxt_r.mem[r_ff.wp] = in_s.data;
         nxt_r.wp = r_ff.wp + 1'h1;
      end
      if (pop) begin
         nxt_r.rp = r_ff.rp + 1'h1;
      end
      nxt_r.cnt = r_ff.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Count never passes capacity
   a_buf_bound: assert property (@(posedge clk) disable iff (!nrst)
      r_ff.cnt <= FULL)
      else $error("buffer occupancy above capacity");
endmodule // seb_buf

// file: verification/seb_ctrl_model.sv
////////////////////////////////////////
// Behavioural two-wire bus controller, pulls data low only
module seb_ctrl_model (
   input wire logic clk,   // Core clock
   input wire logic sda,   // Resolved data wire
   output logic scl,       // Serial clock drive
   output logic sda_pull   // High pulls data low
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus: clock high, data released
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // Half of a 160 ns bus period
   task automatic hp();
      repeat (4) @(posedge clk);
      #1;
   endtask
   // Data falls while clock high; repeated start allowed
   task automatic start();
      sda_pull = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      sda_pull = 1'b1;
      hp();
      scl = 1'b0;
      hp();
   endtask
   // Data rises while clock high
   task automatic stop();
      sda_pull = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_pull = 1'b0;
      hp();
   endtask
   // Data set in clock low, one clock of hold after the fall
   task automatic send_bit(input logic b, output logic r);
      sda_pull = ~b;
      hp();
      scl = 1'b1;
      hp();
      r = sda;
      scl = 1'b0;
      @(posedge clk);
      #1;
   endtask
   // Eight bits MSB first, wire released for the ack
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) send_bit(d[i], r);
      send_bit(1'b1, r);
      ack = ~r;
   endtask
   // Eight bits in, then ack or nack from our side
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         send_bit(1'b1, r);
         d[i] = r;
      end
      send_bit(last, r);
   endtask
   // Clock until data seen high, at most nine, then start
   task automatic recover();
      logic r;
      r = 1'b0;
      repeat (9) if (!r) send_bit(1'b1, r);
      start();
   endtask
endmodule // seb_ctrl_model

// file: verification/serial_eeprom_bus_target_tb_top.sv
module serial_eeprom_bus_target_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned WCYC = 50;
   logic clk, nrst, cs_hi, cs_lo, wp, wr_ready, sda_drv, sda_oe, wr_valid, busy, standby;
   logic scl, pull, sda;
   logic [seb_pkg::ADDR_W-1:0] wr_addr, rd_addr;
   logic [seb_pkg::BYTE_W-1:0] wr_data, rd_data;
   logic [24:0] exp_q[$], got_q[$];
   int mismatches, comparisons;
   // Open-drain wire with pull-up
   assign sda = ~(pull | sda_oe);
   assign rd_data = rd_fn(rd_addr);
   seb_target #(.WRITE_CYCLES(WCYC)) dut (.CLK(clk), .NRST(nrst), .SCL(scl),
      .SDA_LVL(sda), .SDA_DRV(sda_drv), .SDA_OE(sda_oe), .CHIP_SELECT_HIGH(cs_hi),
      .CHIP_SELECT_LOW(cs_lo), .WRITE_PROTECT(wp), .WR_VALID(wr_valid),
      .WR_READY(wr_ready), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_ADDR(rd_addr),
      .RD_DATA(rd_data), .BUSY(busy), .STANDBY(standby));
   seb_ctrl_model ctl (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));
   // 50 MHz core clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Words taken by the array side
   always @(posedge clk) if (wr_valid === 1'b1 && wr_ready === 1'b1)
      got_q.push_back({wr_addr, wr_data});
   ////////////////////////////////////////
   // Array contents seen through the read port
   function automatic logic [7:0] rd_fn(input logic [16:0] a);
      return a[7:0] ^ a[16:9];
   endfunction
   task automatic chkb(input logic g, input logic e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %0t flag got %b exp %b", $time, g, e);
      end
   endtask
   task automatic chkw(input logic [24:0] g, input logic [24:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %0t word got %h exp %h", $time, g, e);
      end
   endtask
   task automatic end_sim();
      if (mismatches == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic dev(input logic [3:0] ty, input logic [1:0] cs, input logic top,
      input logic rw, output logic ack);
      ctl.start();
      ctl.wbyte({ty, cs, top, rw}, ack);
   endtask
   // Device word then high and low address bytes, all acked
   task automatic waddr(input logic [16:0] a);
      logic k;
      dev(4'hA, {cs_hi, cs_lo}, a[16], 1'b0, k);
      chkb(k, 1'b1);
      ctl.wbyte(a[15:8], k);
      chkb(k, 1'b1);
      ctl.wbyte(a[7:0], k);
      chkb(k, 1'b1);
   endtask
   // Bounded wait for the write cycle to finish
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 200) begin
         tick(1);
         n++;
      end
      chkb(standby, 1'b1);
   endtask
   ////////////////////////////////////////
   // Hang guard, well beyond the expected run
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      end_sim();
   end
   initial begin
      int i, j, n;
      logic k;
      logic [7:0] d;
      logic [16:0] a;
      nrst = 1'b0;
      cs_hi = 1'b0;
      cs_lo = 1'b0;
      wp = 1'b0;
      wr_ready = 1'b1;
      mismatches = 0;
      comparisons = 0;
      void'($urandom(57));
      tick(2);
      nrst = 1'b1;
      chkb(standby, 1'b1);
      chkb(sda_oe, 1'b0);
      tick(4);
      ctl.recover();
      ctl.stop();
      // Every select setting: match, wrong selects, wrong type
      for (i = 0; i < 4; i++) begin
         {cs_hi, cs_lo} = 2'(i);
         tick(4);
         for (j = 0; j < 3; j++) begin
            dev(j == 2 ? 4'hB : 4'hA, 2'(i) ^ 2'(j == 1), 1'($urandom), 1'b0, k);
            chkb(k, j == 0);
            ctl.stop();
            chkb(standby, 1'b1);
         end
      end
      // Byte write, then polling while the write cycle runs
      a = 17'($urandom);
      d = 8'($urandom);
      waddr(a);
      ctl.wbyte(d, k);
      chkb(k, 1'b1);
      exp_q.push_back({a, d});
      ctl.stop();
      tick(2);
      chkb(busy, 1'b1);
      chkb(standby, 1'b0);
      dev(4'hA, {cs_hi, cs_lo}, 1'b0, 1'b0, k);
      chkb(k, 1'b0);
      ctl.stop();
      wait_idle();
      dev(4'hA, {cs_hi, cs_lo}, 1'b0, 1'b0, k);
      chkb(k, 1'b1);
      ctl.stop();
      // Stalled array side: page wrap, third word refused
      wr_ready = 1'b0;
      a = {9'($urandom), 8'hFF};
      waddr(a);
      for (n = 0; n < 3; n++) begin
         d = 8'($urandom);
         ctl.wbyte(d, k);
         chkb(k, n < 2);
         if (n < 2) exp_q.push_back({a[16:8], 8'(a[7:0] + n), d});
      end
      ctl.stop();
      tick(3);
      wr_ready = 1'b1;
      wait_idle();
      // Protected array refuses the data byte, no write cycle
      wp = 1'b1;
      tick(4);
      waddr(17'($urandom));
      ctl.wbyte(8'($urandom), k);
      chkb(k, 1'b0);
      ctl.stop();
      tick(4);
      chkb(busy, 1'b0);
      wp = 1'b0;
      // Random reads across a restart, one at the top address
      for (i = 0; i < 2; i++) begin
         a = (i == 0) ? 17'h1FFFF : 17'($urandom);
         waddr(a);
         dev(4'hA, {cs_hi, cs_lo}, 1'($urandom), 1'b1, k);
         chkb(k, 1'b1);
         for (n = 0; n < 3; n++) begin
            ctl.rbyte(n == 2, d);
            chkw({17'h0, d}, {17'h0, rd_fn(17'(a + n))});
         end
         ctl.stop();
         tick(2);
         chkb(standby, 1'b1);
         chkb(sda_drv, 1'b0);
      end
      // Start in mid-byte restarts device word reception
      dev(4'hA, {cs_hi, cs_lo}, 1'b0, 1'b0, k);
      for (n = 0; n < 4; n++) ctl.send_bit(1'($urandom), k);
      dev(4'hA, {cs_hi, cs_lo}, 1'b0, 1'b0, k);
      chkb(k, 1'b1);
      ctl.stop();
      tick(4);
      // Reset in mid-command while the ack is pulled, then bus recovery
      dev(4'hA, {cs_hi, cs_lo}, 1'b0, 1'b0, k);
      nrst = 1'b0;
      tick(2);
      nrst = 1'b1;
      chkb(sda_oe, 1'b0);
      chkb(standby, 1'b1);
      tick(4);
      ctl.recover();
      ctl.stop();
      dev(4'hA, {cs_hi, cs_lo}, 1'b0, 1'b1, k);
      chkb(k, 1'b1);
      ctl.rbyte(1'b1, d);
      ctl.stop();
      tick(4);
      // Array side saw every accepted word, in order
      chkw(25'(got_q.size()), 25'(exp_q.size()));
      foreach (exp_q[x]) if (x < got_q.size()) chkw(got_q[x], exp_q[x]);
      end_sim();
   end
endmodule // serial_eeprom_bus_target_tb_top
